// ---- rtl/crr_pkg.sv ----
package crr_pkg;

   // Detection interval: 2^20 periods of the main oscillation clock.
   localparam int          CRR_INTERVAL_LOG2 = 20;
   localparam int          CRR_RESET_MC      = 5;
   // Extra allowance after standby recovery, in nanoseconds.
   localparam int          CRR_STBY_EXTRA_NS = 20000;
   localparam int          CRR_CLK_PERIOD_NS = 8;
   localparam int          CRR_STBY_EXTRA_CY = CRR_STBY_EXTRA_NS / CRR_CLK_PERIOD_NS;
   localparam int          CRR_MC_DIV        = 1;
   localparam logic [0:0]  CRR_CLEAR_VALUE   = 1'h0;
   localparam logic [0:0]  CRR_RST_IDLE      = 1'h0;

   typedef enum logic [1:0] {
      CRR_IDLE,
      CRR_RUN,
      CRR_FIRE
   } crr_state_e;

endpackage

// ---- rtl/crr_mc_div.sv ----
`timescale 1ns/1ps
// Divides the oscillation clock into one-cycle machine-cycle enables.
module crr_mc_div
   import crr_pkg::*;
#(
   parameter int DIV = CRR_MC_DIV
) (
   input  wire logic clk,
   input  wire logic rst,
   output logic      mc_tick
);

   localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic         next_tick;

   initial begin
      if (DIV < 1) $error("crr_mc_div: DIV must be at least 1");
   end

   always_comb begin
      next_cnt  = cnt;
      next_tick = 1'b0;
      if (DIV == 1) begin
         next_tick = 1'b1;
      end else if (cnt == W'(DIV - 1)) begin
         next_cnt  = '0;
         next_tick = 1'b1;
      end else begin
         next_cnt = cnt + W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt     <= '0;
         mc_tick <= 1'b0;
      end else begin
         cnt     <= next_cnt;
         mc_tick <= next_tick;
      end
   end

endmodule

// ---- rtl/crr_lvr_gate.sv ----
`timescale 1ns/1ps
// Holds off a low-voltage reset request until a RAM write is done, and
// masks it entirely while the runaway reset is being driven.
module crr_lvr_gate (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic lvd_req,
   input  wire logic ram_write_busy,
   input  wire logic int_rst_active,
   output logic      lvr_out
);

   logic next_lvr;

   always_comb begin
      next_lvr = 1'b0;
      if (lvd_req && !ram_write_busy && !int_rst_active) begin
         next_lvr = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lvr_out <= 1'b0;
      end else begin
         lvr_out <= next_lvr;
      end
   end

endmodule

// ---- rtl/crr_top.sv ----
`timescale 1ns/1ps
module crr_top
   import crr_pkg::*;
#(
   parameter int INTERVAL_LOG2 = CRR_INTERVAL_LOG2,
   parameter int STBY_EXTRA    = CRR_STBY_EXTRA_CY,
   parameter int RESET_MC      = CRR_RESET_MC,
   parameter int MC_DIV        = CRR_MC_DIV
) (
   input  wire logic REF_CLK,
   input  wire logic SYS_RST,
   input  wire logic CLEAR_WRITE,
   input  wire logic COUNTER_CLEAR_BIT,
   input  wire logic INT_RESET_IN,
   input  wire logic OSC_STOPPED,
   input  wire logic CPU_STOPPED,
   input  wire logic ENTER_SLEEP,
   input  wire logic ENTER_TIMEBASE,
   input  wire logic ENTER_WATCH,
   input  wire logic STBY_RECOVER,
   input  wire logic LVD_REQ,
   input  wire logic RAM_WRITE_BUSY,
   output logic      RUNAWAY_RESET,
   output logic      LV_RESET,
   output logic      COUNTER_ACTIVE
);

   localparam int CW = INTERVAL_LOG2 + 1;
   localparam int EW = (STBY_EXTRA > 1) ? $clog2(STBY_EXTRA + 1) : 1;
   localparam int RW = $clog2(RESET_MC + 1);

   initial begin
      if (INTERVAL_LOG2 < 1 || INTERVAL_LOG2 > 30) $error("crr_top: bad INTERVAL_LOG2");
      if (RESET_MC < 1) $error("crr_top: RESET_MC must be at least 1");
      if (STBY_EXTRA < 0) $error("crr_top: STBY_EXTRA must not be negative");
      if (MC_DIV < 1) $error("crr_top: MC_DIV must be at least 1");
   end

   crr_state_e   state;
   crr_state_e   next_state;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic [EW-1:0] extra;
   logic [EW-1:0] next_extra;
   logic [RW-1:0] mc_left;
   logic [RW-1:0] next_mc_left;
   logic          next_rst_out;
   logic          next_active;
   logic          mc_tick;
   logic          clear_req;
   logic          mode_entry;
   logic          lvr_q;

   crr_mc_div #(
      .DIV     (MC_DIV)
   ) u_div (
      .clk     (REF_CLK),
      .rst     (SYS_RST),
      .mc_tick (mc_tick)
   );

   crr_lvr_gate u_lvr (
      .clk            (REF_CLK),
      .rst            (SYS_RST),
      .lvd_req        (LVD_REQ),
      .ram_write_busy (RAM_WRITE_BUSY),
      .int_rst_active (RUNAWAY_RESET),
      .lvr_out        (lvr_q)
   );

   logic          sw_clear;
   logic          reset_clear;
   logic          osc_clear;
   logic          overflow;
   logic          extra_pending;
   logic          run_now;
   logic          fire_now;
   logic          pulse_end;
   logic          next_lv;

   // Each clear source but the three mode entries, which share mode_entry, is decoded on its own so it can be traced to its rule.
   assign sw_clear    = CLEAR_WRITE && (COUNTER_CLEAR_BIT == CRR_CLEAR_VALUE);
   assign reset_clear = INT_RESET_IN;
   assign osc_clear   = OSC_STOPPED;
   assign mode_entry  = ENTER_SLEEP || ENTER_TIMEBASE || ENTER_WATCH;
   assign clear_req   = sw_clear || reset_clear || osc_clear || mode_entry;

   // The top bit of the count is the overflow of the interval counter.
   assign overflow      = cnt[CW-1];
   assign extra_pending = (extra != '0);
   assign run_now       = (state == CRR_RUN);
   // A clear or a stopped processor in the same cycle always wins over expiry.
   assign fire_now      = run_now && !clear_req && !CPU_STOPPED && overflow && !extra_pending;
   assign pulse_end     = (state == CRR_FIRE) && mc_tick && (mc_left == RW'(1));

   // Sequencing group.
   always_comb begin
      next_state = state;
      case (state)
         CRR_IDLE: begin
            next_state = CRR_RUN;
         end
         CRR_RUN: begin
            if (fire_now) begin
               next_state = CRR_FIRE;
            end
         end
         CRR_FIRE: begin
            if (pulse_end) begin
               next_state = CRR_RUN;
            end
         end
         default: begin
            next_state = CRR_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         state <= CRR_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Interval count group.
   always_comb begin
      next_cnt = cnt;
      case (state)
         CRR_IDLE: begin
            next_cnt = '0;
         end
         CRR_RUN: begin
            if (clear_req) begin
               next_cnt = '0;
            end else if (CPU_STOPPED) begin
               next_cnt = cnt;
            end else if (fire_now) begin
               next_cnt = '0;
            end else if (!overflow) begin
               next_cnt = cnt + CW'(1);
            end
         end
         CRR_FIRE: begin
            // Clears during the pulse are ignored; the pulse itself restarts the count.
            if (pulse_end) begin
               next_cnt = '0;
            end
         end
         default: begin
            next_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // Standby allowance group.
   always_comb begin
      next_extra = extra;
      if (run_now) begin
         if (STBY_RECOVER) begin
            next_extra = EW'(STBY_EXTRA);
         end
         if (clear_req) begin
            next_extra = '0;
         end else if (!CPU_STOPPED && overflow && extra_pending) begin
            // The allowance is only spent once the interval has run out.
            next_extra = extra - EW'(1);
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         extra <= '0;
      end else begin
         extra <= next_extra;
      end
   end

   // Reset pulse group.
   always_comb begin
      next_mc_left = mc_left;
      next_rst_out = CRR_RST_IDLE;
      case (state)
         CRR_RUN: begin
            if (fire_now) begin
               next_mc_left = RW'(RESET_MC);
               next_rst_out = 1'b1;
            end
         end
         CRR_FIRE: begin
            next_rst_out = 1'b1;
            if (mc_tick) begin
               next_mc_left = mc_left - RW'(1);
            end
            if (pulse_end) begin
               next_rst_out = CRR_RST_IDLE;
            end
         end
         default: begin
            next_rst_out = CRR_RST_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         mc_left       <= '0;
         RUNAWAY_RESET <= CRR_RST_IDLE;
      end else begin
         mc_left       <= next_mc_left;
         RUNAWAY_RESET <= next_rst_out;
      end
   end

   // Status group.
   always_comb begin
      next_active = 1'b0;
      next_lv     = lvr_q;
      if (run_now) begin
         next_active = !CPU_STOPPED;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         COUNTER_ACTIVE <= 1'b0;
         LV_RESET       <= 1'b0;
      end else begin
         COUNTER_ACTIVE <= next_active;
         LV_RESET       <= next_lv;
      end
   end

endmodule

// ---- verification/crr_top_sva.sv ----
`timescale 1ns/1ps
module crr_sva (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic CLEAR_WRITE,
   input wire logic COUNTER_CLEAR_BIT,
   input wire logic CPU_STOPPED,
   input wire logic LVD_REQ,
   input wire logic RAM_WRITE_BUSY,
   input wire logic RUNAWAY_RESET,
   input wire logic LV_RESET,
   input wire logic COUNTER_ACTIVE
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   // The gated path lags its cause by two clocks, so each check waits for a settled cause.
   chk_lv_block: assert property (RUNAWAY_RESET [*3] |-> !LV_RESET) else $error("lv in runaway");
   chk_lv_hold: assert property (RAM_WRITE_BUSY [*3] |-> !LV_RESET) else $error("lv in ram write");
   chk_lv_raise: assert property ((LVD_REQ && !RAM_WRITE_BUSY && !RUNAWAY_RESET) [*3] |-> LV_RESET)
      else $error("lv missing");
   chk_pulse_len: assert property ($rose(RUNAWAY_RESET) |-> RUNAWAY_RESET [*5] ##[1:2] !RUNAWAY_RESET)
      else $error("bad pulse");
   chk_stop_hold: assert property (CPU_STOPPED [*2] |-> !COUNTER_ACTIVE) else $error("active stopped");
   chk_start_run: assert property ($fell(SYS_RST) && !CPU_STOPPED |-> ##[1:3] COUNTER_ACTIVE)
      else $error("no start");
   chk_idle_out: assert property ($fell(SYS_RST) |-> !RUNAWAY_RESET && !LV_RESET) else $error("busy out");
   chk_clr_quiet: assert property ((CLEAR_WRITE && !COUNTER_CLEAR_BIT) ##2 !RUNAWAY_RESET |=> !RUNAWAY_RESET [*8])
      else $error("early fire");
   cover property ($rose(RUNAWAY_RESET));
   cover property ($rose(LV_RESET));
   cover property (CPU_STOPPED ##1 !CPU_STOPPED);
endmodule
bind crr_top crr_sva u_sva (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CLEAR_WRITE(CLEAR_WRITE),
   .COUNTER_CLEAR_BIT(COUNTER_CLEAR_BIT), .CPU_STOPPED(CPU_STOPPED), .LVD_REQ(LVD_REQ),
   .RAM_WRITE_BUSY(RAM_WRITE_BUSY), .RUNAWAY_RESET(RUNAWAY_RESET), .LV_RESET(LV_RESET),
   .COUNTER_ACTIVE(COUNTER_ACTIVE));

// ---- verification/test_cpu_runaway_reset_counter.sv ----
`timescale 1ns/1ps
module test_cpu_runaway_reset_counter;
   localparam int L = 6;
   localparam int P = 1 << L;
   logic       clk = 1'b0, rst = 1'b1, cb = 1'b1, lvd = 1'b0, ram = 1'b0, rr, lv, rr_q, lv_q, act;
   logic [7:0] ev = 8'h00;
   int         cyc, failures, n_tests, i, q[$];
   crr_top #(.INTERVAL_LOG2(L), .STBY_EXTRA(3)) dut (.REF_CLK(clk), .SYS_RST(rst), .CLEAR_WRITE(ev[0]),
      .COUNTER_CLEAR_BIT(cb), .INT_RESET_IN(ev[1]), .OSC_STOPPED(ev[2]), .ENTER_SLEEP(ev[3]),
      .ENTER_TIMEBASE(ev[4]), .ENTER_WATCH(ev[5]), .STBY_RECOVER(ev[6]), .CPU_STOPPED(ev[7]),
      .LVD_REQ(lvd), .RAM_WRITE_BUSY(ram), .RUNAWAY_RESET(rr), .LV_RESET(lv), .COUNTER_ACTIVE(act));
   initial begin
      forever #4 clk = ~clk;
   end
   task tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task pulse(input int k, input logic b);
      ev[k] = 1'b1;
      cb = b;
      tick(1);
      ev = 8'h00;
      cb = 1'b1;
   endtask
   // Two cycles of slack absorb the registered stages around each reset edge.
   task chk;
      n_tests++;
      if (q.size() == 0 || cyc > q[0] + 2 || cyc + 2 < q[0]) begin
         failures++;
         $display("Error %0t reset edge at cycle %0d", $time, cyc);
      end
      if (q.size() > 0) void'(q.pop_front());
   endtask
   task results;
      if (failures == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) cyc <= cyc + 1;
   always @(negedge clk) begin
      if (rr === 1'b1 && rr_q !== 1'b1) chk;
      if (lv === 1'b1 && lv_q !== 1'b1) chk;
      rr_q = rr;
      lv_q = lv;
      if (cyc > 5000) begin
         failures++;
         results;
      end
   end
   initial begin
      void'($urandom(9914));
      tick(16);
      rst = 1'b0;
      q.push_back(cyc + P + 3);
      tick(P + 12);
      for (i = 0; i < 18; i++) begin
         tick($urandom_range(P - 10, 1));
         pulse(i < 6 ? i : $urandom % 6, 1'b0);
      end
      pulse(0, 1'b0);
      q.push_back(cyc + P + 2);
      tick(20);
      pulse(0, 1'b1);
      tick(P);
      pulse(3, 1'b0);
      q.push_back(cyc + P + 22);
      tick(10);
      ev[7] = 1'b1;
      tick(20);
      n_tests++;
      if (act !== 1'b0) begin
         failures++;
         $display("Error %0t counter active while processor stopped", $time);
      end
      ev[7] = 1'b0;
      tick(P + 4);
      n_tests++;
      if (act !== 1'b1) begin
         failures++;
         $display("Error %0t counter not active while running", $time);
      end
      pulse(4, 1'b0);
      q.push_back(cyc + P + 5);
      pulse(6, 1'b1);
      tick(P + 16);
      lvd = 1'b1;
      ram = 1'b1;
      tick(5);
      ram = 1'b0;
      q.push_back(cyc + 2);
      tick(8);
      lvd = 1'b0;
      tick(4);
      if (q.size() > 0) chk;
      results;
   end
endmodule
